/* rtl/line_codec_defs.svh */
// offsets, field positions, reset values and timing counts of the command register bank
`ifndef LINE_CODEC_DEFS_SVH
`define LINE_CODEC_DEFS_SVH

// ------------------------------------------------------------
// command bytes and register offsets
// ------------------------------------------------------------
`define CMD_Z_IIR_WR      8'h9A
`define CMD_Z_IIR_RD      8'h9B
`define CMD_DBC_WR        8'hC8
`define CMD_DBC_RD        8'hC9
`define CMD_TX_RD         8'hCD
`define CMD_GK_WR         8'hE8
`define CMD_GK_RD         8'hE9
`define CMD_RW_BIT        0

// ------------------------------------------------------------
// field layout and reset values
// ------------------------------------------------------------
`define Z_IIR_BYTES       3'd5
`define Z_IIR_LAST        3'd4
`define Z_IIR_RESET       40'h01_90_90_01_90
`define DBC_STB_EN        7
`define DBC_STB_POL       6
`define DBC_TIME_HI       5
`define DBC_TIME_LO       2
`define DBC_RSVD          1
`define DBC_CHOP_EN       0
`define DBC_RESET         8'h20
`define GK_RESET          4'h0
`define RSVD_BYTE         8'h00

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define CLK_HZ            40000000
`define MS_TICK_US        1000
`define MS_CYCLES         ((`CLK_HZ / 1000000) * `MS_TICK_US)
`define ZF_RATE_HZ        32000
`define ZF_CYCLES         (`CLK_HZ / `ZF_RATE_HZ)
`define CHOP_HZ           256000
`define CHOP_HALF_CYCLES  (`CLK_HZ / (2 * `CHOP_HZ))
`define ZF_CNT_W          11
`define CHOP_CNT_W        7
`define MS_CNT_W          16

`endif

/* rtl/line_codec_pkg.sv */
// types shared by the command register bank
package line_codec_pkg;

   typedef enum logic [1:0] {
      S_IDLE,
      S_WR,
      S_RD
   } cmd_state_e;

   typedef struct packed {
      logic       valid;
      logic       is_cmd;
      logic [7:0] data;
   } host_in_s;

   typedef struct packed {
      logic        valid;
      logic [1:0]  chan;
      logic [15:0] sample;
   } tx_in_s;

   typedef struct packed {
      logic signed [1:0] weight;
      logic [2:0]        shift;
   } csd_term_s;

   typedef struct packed {
      csd_term_s [3:0] z5;
      csd_term_s [1:0] z6;
      csd_term_s [3:0] z7;
   } z_rec_s;

endpackage : line_codec_pkg

/* rtl/csd_term_decode.sv */
// decodes the five recursive coefficient bytes into signed shift terms
`timescale 1ns/1ps
module csd_term_decode
   import line_codec_pkg::*;
(
   input  wire logic [39:0] raw,
   output z_rec_s           terms
);

   csd_term_s [9:0] flat;

   // ------------------------------------------------------------
   // one nibble per term: sign on top, shift count below
   // ------------------------------------------------------------
   genvar k;
   generate
      for (k = 0; k < 10; k++) begin : g_term
         assign flat[k].weight = raw[4*k+3] ? -2'sd1 : 2'sd1;  // RQ3
         assign flat[k].shift  = raw[4*k+2 -: 3];              // RQ4
      end
   endgenerate

   // byte 1 holds z5 terms 4,3 down to byte 5 with z7 terms 2,1
   assign terms.z5 = flat[9:6];  // RQ2
   assign terms.z6 = flat[5:4];  // RQ6
   assign terms.z7 = flat[3:0];

endmodule : csd_term_decode

/* rtl/line_codec_misc_command_regs.sv */
// command register bank: recursive z coefficients, debounce/strobe, tx sample, ground key
//
// Contract
// RQ1 - 9Ah/9Bh touch only recursive z coefficients
// RQ2 - five bytes, z5 z5 z6 z7 z7
// RQ3 - sign bit zero positive, one negative
// RQ4 - nibble is sign then 3-bit shift
// RQ5 - z filter runs at 32 kHz
// RQ6 - z6 scales recursive section input by reciprocal
// RQ7 - output times z6, gain z5/z6
// RQ8 - coefficient words reset to 0190h
// RQ9 - C8h/C9h one register for all channels
// RQ10 - strobe en, pol, debounce, reserved, chopper
// RQ11 - strobe enable bit turns strobing on
// RQ12 - polarity bit selects high or low pulse
// RQ13 - no strobe output unless pin mode set
// RQ14 - hook stable debounce ms; reset 20h
// RQ15 - reserved bits written zero, read anything
// RQ16 - chopper enable drives chopper clock
// RQ17 - Transmit_sample_readback returns sample byte then reserved
// RQ18 - linear mode returns upper sample byte
// RQ19 - armed channel interrupts on new sample
// RQ20 - E8h/E9h ground key period bits 3:0
// RQ21 - ground key filters detect input one b
// RQ22 - period zero bypasses; resets to x0h
`timescale 1ns/1ps
`include "line_codec_defs.svh"
module line_codec_misc_command_regs
   import line_codec_pkg::*;
#(
   parameter int MS_CYCLES = `MS_CYCLES
) (
   input  wire logic       clk,
   input  wire logic       rst,
   input  host_in_s        host_in,
   input  wire logic       rd_req,
   output logic            rd_valid,
   output logic [7:0]      rd_byte,
   input  wire logic [1:0] chan_sel,
   input  wire logic       pin_mode_selector,
   input  wire logic       linear_mode,
   input  wire logic [3:0] tx_interrupt_arm,
   input  tx_in_s          tx_in,
   input  wire logic [3:0] detect_input_one,
   input  wire logic [3:0] detect_input_one_b,
   output logic [3:0]      rt_hook,
   output logic [3:0]      rt_ground,
   output logic            mux_strobe_output,
   output logic            mux_strobe_oe,
   output logic            chopper_clock_out,
   output logic            z_filter_tick,
   output z_rec_s [3:0]    z_coeffs,
   output logic [3:0]      tx_irq
);

   // ------------------------------------------------------------
   // command state
   // ------------------------------------------------------------
   cmd_state_e        state_q, state_d;
   logic [7:0]        cmd_q, cmd_d;
   logic [2:0]        idx_q, idx_d;
   logic [39:0]       shadow_q, shadow_d;
   logic [39:0]       coef_q [4];
   logic [39:0]       coef_d [4];
   logic [7:0]        dbc_q, dbc_d;
   logic [3:0]        gk_q [4];
   logic [3:0]        gk_d [4];
   logic [7:0]        txb_q [4];
   logic [7:0]        txb_d [4];
   logic [3:0]        irq_q, irq_d;
   logic              rdv_q, rdv_d;
   logic [7:0]        rdb_q, rdb_d;
   logic              data_in;

   assign data_in = host_in.valid && !host_in.is_cmd;

   always_comb begin
      logic [39:0] sh;
      sh       = '0;
      state_d  = state_q;
      cmd_d    = cmd_q;
      idx_d    = idx_q;
      shadow_d = shadow_q;
      coef_d   = coef_q;
      dbc_d    = dbc_q;
      gk_d     = gk_q;
      txb_d    = txb_q;
      irq_d    = irq_q;
      rdv_d    = 1'b0;
      rdb_d    = rdb_q;
      if (host_in.valid && host_in.is_cmd) begin
         cmd_d = host_in.data;
         idx_d = 3'd0;
         case (host_in.data)
            `CMD_Z_IIR_WR, `CMD_DBC_WR, `CMD_GK_WR:               state_d = S_WR;
            `CMD_Z_IIR_RD, `CMD_DBC_RD, `CMD_TX_RD, `CMD_GK_RD:   state_d = S_RD;
            default:                                               state_d = S_IDLE;
         endcase
      end else if (data_in && state_q == S_WR) begin
         case (cmd_q)
            `CMD_Z_IIR_WR: begin
               shadow_d = {shadow_q[31:0], host_in.data};              // RQ2
               idx_d    = idx_q + 3'd1;
               if (idx_q == `Z_IIR_LAST) begin
                  coef_d[chan_sel] = {shadow_q[31:0], host_in.data};   // RQ1
                  state_d          = S_IDLE;
               end
            end
            `CMD_DBC_WR: begin
               dbc_d   = host_in.data;                                 // RQ9 RQ10
               state_d = S_IDLE;
            end
            `CMD_GK_WR: begin
               gk_d[chan_sel] = host_in.data[3:0];                     // RQ20
               state_d        = S_IDLE;
            end
            default: state_d = S_IDLE;
         endcase
      end else if (rd_req && state_q == S_RD) begin
         rdv_d = 1'b1;
         idx_d = idx_q + 3'd1;
         case (cmd_q)
            `CMD_Z_IIR_RD: begin
               sh    = coef_q[chan_sel] >> {3'(`Z_IIR_LAST - idx_q), 3'b000};
               rdb_d = sh[7:0];                                        // RQ1 RQ2
               if (idx_q == `Z_IIR_LAST) begin
                  state_d = S_IDLE;
               end
            end
            `CMD_DBC_RD: begin
               rdb_d   = dbc_q;                                        // RQ15
               state_d = S_IDLE;
            end
            `CMD_TX_RD: begin
               if (idx_q == 3'd0) begin
                  rdb_d           = txb_q[chan_sel];                   // RQ17
                  irq_d[chan_sel] = 1'b0;                              // RQ19
               end else begin
                  rdb_d   = `RSVD_BYTE;
                  state_d = S_IDLE;
               end
            end
            `CMD_GK_RD: begin
               rdb_d   = {4'h0, gk_q[chan_sel]};                       // RQ20
               state_d = S_IDLE;
            end
            default: begin
               rdb_d   = `RSVD_BYTE;
               state_d = S_IDLE;
            end
         endcase
      end
      if (tx_in.valid) begin
         txb_d[tx_in.chan] = linear_mode ? tx_in.sample[15:8] : tx_in.sample[7:0];  // RQ18
         if (tx_interrupt_arm[tx_in.chan]) begin
            irq_d[tx_in.chan] = 1'b1;                                  // RQ19
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_q  <= S_IDLE;
         cmd_q    <= 8'h00;
         idx_q    <= 3'd0;
         shadow_q <= 40'h00_0000_0000;
         for (int c = 0; c < 4; c++) begin
            coef_q[c] <= `Z_IIR_RESET;                                 // RQ8
            gk_q[c]   <= `GK_RESET;                                    // RQ22
            txb_q[c]  <= 8'h00;
         end
         dbc_q    <= `DBC_RESET;                                       // RQ14
         irq_q    <= 4'h0;
         rdv_q    <= 1'b0;
         rdb_q    <= 8'h00;
      end else begin
         state_q  <= state_d;
         cmd_q    <= cmd_d;
         idx_q    <= idx_d;
         shadow_q <= shadow_d;
         coef_q   <= coef_d;
         gk_q     <= gk_d;
         txb_q    <= txb_d;
         dbc_q    <= dbc_d;
         irq_q    <= irq_d;
         rdv_q    <= rdv_d;
         rdb_q    <= rdb_d;
      end
   end

   assign rd_valid = rdv_q;
   assign rd_byte  = rdb_q;
   assign tx_irq   = irq_q;

   // ------------------------------------------------------------
   // coefficient decode per channel
   // ------------------------------------------------------------
   genvar ch;
   generate
      for (ch = 0; ch < 4; ch++) begin : g_dec
         // z6 goes to the datapath both as input 1/z6 and output z6 scale
         csd_term_decode u_dec (
            .raw   (coef_q[ch]),
            .terms (z_coeffs[ch])                                      // RQ6 RQ7
         );
      end
   endgenerate

   // ------------------------------------------------------------
   // time bases, strobe and chopper
   // ------------------------------------------------------------
   logic [`ZF_CNT_W-1:0]   zf_cnt_q, zf_cnt_d;
   logic [`CHOP_CNT_W-1:0] ch_cnt_q, ch_cnt_d;
   logic [`MS_CNT_W-1:0]   ms_cnt_q, ms_cnt_d;
   logic                   zf_tick_q, zf_tick_d;
   logic                   ms_tick_q, ms_tick_d;
   logic                   chop_q, chop_d;
   logic                   stb_q, stb_d;
   logic                   stb_oe_q, stb_oe_d;

   always_comb begin
      zf_tick_d = (zf_cnt_q == `ZF_CNT_W'(`ZF_CYCLES - 1));
      zf_cnt_d  = zf_tick_d ? '0 : zf_cnt_q + 1'b1;                   // RQ5
      ms_tick_d = (ms_cnt_q == `MS_CNT_W'(MS_CYCLES - 1));
      ms_cnt_d  = ms_tick_d ? '0 : ms_cnt_q + 1'b1;
      ch_cnt_d  = ch_cnt_q + 1'b1;
      chop_d    = chop_q;
      if (ch_cnt_q == `CHOP_CNT_W'(`CHOP_HALF_CYCLES - 1)) begin
         ch_cnt_d = '0;
         chop_d   = ~chop_q;
      end
      if (!dbc_q[`DBC_CHOP_EN]) begin
         chop_d = 1'b0;                                                // RQ16
      end
      // one-cycle pulse each sample period while strobe enable is set, idle level set by polarity
      stb_d    = dbc_q[`DBC_STB_POL] ^ (zf_tick_q & dbc_q[`DBC_STB_EN]);  // RQ11 RQ12
      stb_oe_d = pin_mode_selector & dbc_q[`DBC_STB_EN];              // RQ13
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         zf_cnt_q  <= '0;
         ms_cnt_q  <= '0;
         ch_cnt_q  <= '0;
         zf_tick_q <= 1'b0;
         ms_tick_q <= 1'b0;
         chop_q    <= 1'b0;
         stb_q     <= 1'b0;
         stb_oe_q  <= 1'b0;
      end else begin
         zf_cnt_q  <= zf_cnt_d;
         ms_cnt_q  <= ms_cnt_d;
         ch_cnt_q  <= ch_cnt_d;
         zf_tick_q <= zf_tick_d;
         ms_tick_q <= ms_tick_d;
         chop_q    <= chop_d;
         stb_q     <= stb_d;
         stb_oe_q  <= stb_oe_d;
      end
   end

   assign z_filter_tick     = zf_tick_q;
   assign chopper_clock_out = chop_q;
   assign mux_strobe_output = stb_q;
   assign mux_strobe_oe     = stb_oe_q;

   // ------------------------------------------------------------
   // hook debounce and ground key filter per channel
   // ------------------------------------------------------------
   generate
      for (ch = 0; ch < 4; ch++) begin : g_rt
         logic [3:0] hk_cnt_q, hk_cnt_d;
         logic [3:0] gk_cnt_q, gk_cnt_d;
         logic       hook_q, hook_d;
         logic       gnd_q, gnd_d;

         always_comb begin
            hk_cnt_d = hk_cnt_q;
            hook_d   = hook_q;
            if (detect_input_one[ch] == hook_q) begin
               hk_cnt_d = 4'h0;
            end else if (hk_cnt_q >= dbc_q[`DBC_TIME_HI:`DBC_TIME_LO]) begin
               hook_d   = detect_input_one[ch];                        // RQ14
               hk_cnt_d = 4'h0;
            end else if (ms_tick_q) begin
               hk_cnt_d = hk_cnt_q + 4'h1;
            end
            gk_cnt_d = gk_cnt_q;
            gnd_d    = gnd_q;
            if (gk_q[ch] == 4'h0) begin
               gnd_d    = detect_input_one_b[ch];                      // RQ22
               gk_cnt_d = 4'h0;
            end else if (ms_tick_q) begin
               if (gk_cnt_q + 4'h1 >= gk_q[ch]) begin
                  gnd_d    = detect_input_one_b[ch];                   // RQ21
                  gk_cnt_d = 4'h0;
               end else begin
                  gk_cnt_d = gk_cnt_q + 4'h1;
               end
            end
         end

         always_ff @(posedge clk) begin
            if (rst) begin
               hk_cnt_q <= 4'h0;
               gk_cnt_q <= 4'h0;
               hook_q   <= 1'b0;
               gnd_q    <= 1'b0;
            end else begin
               hk_cnt_q <= hk_cnt_d;
               gk_cnt_q <= gk_cnt_d;
               hook_q   <= hook_d;
               gnd_q    <= gnd_d;
            end
         end

         assign rt_hook[ch]   = hook_q;
         assign rt_ground[ch] = gnd_q;
      end
   endgenerate

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking

   chk_iir_commit : assert property (disable iff (rst)  // RQ1
      (state_q == S_WR && cmd_q == `CMD_Z_IIR_WR && data_in && idx_q == `Z_IIR_LAST)
      |=> coef_q[$past(chan_sel)] == {$past(shadow_q[31:0]), $past(host_in.data)})
      else $error("recursive coefficients not committed");

   chk_iir_first_byte : assert property (disable iff (rst)  // RQ2
      (state_q == S_RD && cmd_q == `CMD_Z_IIR_RD && rd_req && idx_q == 3'd0
       && !host_in.valid)
      |=> rd_valid && rd_byte == $past(coef_q[chan_sel][39:32]))
      else $error("first coefficient byte wrong");

   chk_coef_reset : assert property (  // RQ8
      rst |=> coef_q[0] == `Z_IIR_RESET && coef_q[3] == `Z_IIR_RESET
              && dbc_q == `DBC_RESET)
      else $error("reset value wrong");

   chk_strobe_gate : assert property (disable iff (rst)  // RQ13
      !pin_mode_selector |=> !mux_strobe_oe)
      else $error("strobe driven without pin mode");

   chk_strobe_pulse : assert property (disable iff (rst)  // RQ12
      (zf_tick_q && dbc_q[`DBC_STB_EN] && $stable(dbc_q))
      |=> mux_strobe_output == !$past(dbc_q[`DBC_STB_POL])
          ##1 mux_strobe_output == $past(dbc_q[`DBC_STB_POL]))
      else $error("strobe pulse shape wrong");

   chk_rate_tick : assert property (disable iff (rst)  // RQ5
      z_filter_tick |=> (!z_filter_tick)[*8])
      else $error("sample tick too frequent");

   chk_chop_off : assert property (disable iff (rst)  // RQ16
      !dbc_q[`DBC_CHOP_EN] |=> !chopper_clock_out)
      else $error("chopper runs while disabled");

   chk_irq_set : assert property (disable iff (rst)  // RQ19
      (tx_in.valid && tx_in.chan == 2'd0 && tx_interrupt_arm[0]) |=> tx_irq[0])
      else $error("armed interrupt not raised");

   chk_gk_bypass : assert property (disable iff (rst)  // RQ22
      (gk_q[0] == 4'h0) |=> rt_ground[0] == $past(detect_input_one_b[0]))
      else $error("ground key bypass wrong");

   chk_sign_decode : assert property (disable iff (rst)  // RQ3
      z_coeffs[0].z5[3].weight == {coef_q[0][39], 1'b1}
      && z_coeffs[0].z5[3].shift == coef_q[0][38:36])
      else $error("coefficient term decode wrong");

   cov_iir_write : cover property (disable iff (rst)
      state_q == S_WR && cmd_q == `CMD_Z_IIR_WR && data_in && idx_q == `Z_IIR_LAST);
   cov_tx_read : cover property (disable iff (rst)
      tx_irq[0] ##[1:20] !tx_irq[0]);
   cov_strobe : cover property (disable iff (rst)
      mux_strobe_oe && $changed(mux_strobe_output));

endmodule : line_codec_misc_command_regs

/* bench/host_cpu_model.sv */
// host microprocessor model issuing command bytes, data bytes and read requests
`timescale 1ns/1ps
module host_cpu_model
   import line_codec_pkg::*;
(
   input  wire logic       clk,
   output host_in_s        host_in,
   output logic            rd_req,
   input  wire logic       rd_valid,
   input  wire logic [7:0] rd_byte
);
   logic [7:0] last_b;

   initial begin
      host_in = '0;
      rd_req = 1'b0;
      last_b = 8'h00;
   end

   // ------------------------------------------------------------
   // one byte every two cycles; the released data bus shows the inverse of the last byte
   // ------------------------------------------------------------
   task automatic put(input logic is_cmd, input logic [7:0] b);
      @(negedge clk);
      host_in = '{valid: 1'b1, is_cmd: is_cmd, data: b};
      last_b = b;
      @(negedge clk);
      host_in = '{valid: 1'b0, is_cmd: 1'b0, data: ~last_b};
   endtask : put

   // unknown result when no answer arrives
   task automatic get(output logic [7:0] b);
      b = 8'hXX;
      @(negedge clk);
      rd_req = 1'b1;
      @(negedge clk);
      rd_req = 1'b0;
      for (int n = 0; n < 3; n++) begin
         if (rd_valid === 1'b1) begin
            b = rd_byte;
            break;
         end
         @(negedge clk);
      end
   endtask : get
endmodule : host_cpu_model

/* bench/line_codec_misc_command_regs_tb_top.sv */
// self-checking bench for the command register bank
`timescale 1ns/1ps
module line_codec_misc_command_regs_tb_top
   import line_codec_pkg::*;
;
   localparam int MS = 40;
   logic         clk = 1'b0;
   logic         rst = 1'b1;
   host_in_s     host_in;
   logic         rd_req;
   logic         rd_valid;
   logic [7:0]   rd_byte;
   logic [1:0]   chan_sel = 2'h0;
   logic         pin_mode_selector = 1'b0;
   logic         linear_mode = 1'b0;
   logic [3:0]   tx_interrupt_arm = 4'h0;
   tx_in_s       tx_in = '0;
   logic [3:0]   detect_input_one = 4'h0;
   logic [3:0]   detect_input_one_b = 4'h0;
   logic [3:0]   rt_hook, rt_ground, tx_irq;
   logic         mux_strobe_output, mux_strobe_oe, chopper_clock_out, z_filter_tick;
   z_rec_s [3:0] z_coeffs;
   logic [39:0]  coef [4];
   logic [31:0]  seed = 32'h0000_3D84;
   int           fail_count = 0;
   int           checks = 0;

   always #12.5 clk = ~clk;

   line_codec_misc_command_regs #(.MS_CYCLES(MS)) i_dut (
      .clk(clk), .rst(rst), .host_in(host_in), .rd_req(rd_req), .rd_valid(rd_valid),
      .rd_byte(rd_byte), .chan_sel(chan_sel), .pin_mode_selector(pin_mode_selector),
      .linear_mode(linear_mode), .tx_interrupt_arm(tx_interrupt_arm), .tx_in(tx_in),
      .detect_input_one(detect_input_one), .detect_input_one_b(detect_input_one_b),
      .rt_hook(rt_hook), .rt_ground(rt_ground), .mux_strobe_output(mux_strobe_output),
      .mux_strobe_oe(mux_strobe_oe), .chopper_clock_out(chopper_clock_out),
      .z_filter_tick(z_filter_tick), .z_coeffs(z_coeffs), .tx_irq(tx_irq));

   host_cpu_model i_host (.clk(clk), .host_in(host_in), .rd_req(rd_req),
      .rd_valid(rd_valid), .rd_byte(rd_byte));

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [7:0] rnd8();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction : rnd8

   // expected signed shift terms, first nibble is the highest term of z5
   function automatic z_rec_s dec(input logic [39:0] r);
      z_rec_s     z;
      csd_term_s  t;
      logic [3:0] n;
      for (int i = 0; i < 10; i++) begin
         n = r[39-4*i -: 4];
         t = {n[3] ? 2'h3 : 2'h1, n[2:0]};
         if (i < 4) z.z5[3-i] = t;
         else if (i < 6) z.z6[5-i] = t;
         else z.z7[9-i] = t;
      end
      return z;
   endfunction : dec

   task automatic chk_v(input logic [63:0] got, input logic [63:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %0t %s got %0h exp %0h", $time, what, got, exp);
      end
   endtask : chk_v

   task automatic chk_n(input int got, input int exp, input string what);
      checks++;
      if (got != exp) begin
         fail_count++;
         $display("BAD %0t %s got %0d exp %0d", $time, what, got, exp);
      end
   endtask : chk_n

   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask : cyc

   task automatic rd_chk(input logic [7:0] exp, input string what);
      logic [7:0] b;
      i_host.get(b);
      chk_v(b, exp, what);
   endtask : rd_chk

   task automatic wr(input logic [7:0] cmd, input logic [7:0] d);
      i_host.put(1'b1, cmd);
      i_host.put(1'b0, d);
   endtask : wr

   task automatic hook_test(input int i, input int ms);
      logic nv;
      nv = ~detect_input_one[i];
      detect_input_one[i] = nv;
      cyc((ms - 1) * MS - 5);
      chk_v(rt_hook[i], !nv, "hook early");
      cyc(2 * MS + 10);
      chk_v(rt_hook[i], nv, "hook late");
   endtask : hook_test

   task automatic close_out();
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : close_out

   initial begin
      repeat (60000) @(posedge clk);
      fail_count++;
      $display("BAD %0t watchdog expired", $time);
      close_out();
   end

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      logic [39:0] w;
      logic [15:0] s;
      logic [7:0]  v;
      int          n;
      int          q;
      int          p;
      repeat (6) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      for (int ch = 0; ch < 4; ch++) begin
         coef[ch] = 40'h01_9090_0190;
         chan_sel = ch[1:0];
         i_host.put(1'b1, 8'h9B);
         for (int k = 0; k < 5; k++) rd_chk(coef[ch][39-8*k -: 8], "z reset");
         chk_v(z_coeffs[ch], dec(coef[ch]), "z decode");
         i_host.put(1'b1, 8'hE9);
         rd_chk(8'h00, "gk reset");
      end
      i_host.put(1'b1, 8'hC9);
      rd_chk(8'h20, "dbc reset");
      hook_test(0, 8);
      // last pass is cut short by a new command and must leave the words alone
      for (int it = 0; it < 6; it++) begin
         p = int'(rnd8() & 8'h03);
         chan_sel = p[1:0];
         i_host.put(1'b1, 8'h9A);
         for (int k = 0; k < ((it == 5) ? 3 : 5); k++) begin
            w[39-8*k -: 8] = rnd8();
            i_host.put(1'b0, w[39-8*k -: 8]);
         end
         if (it != 5) coef[p] = w;
         i_host.put(1'b1, 8'h9B);
         for (int k = 0; k < 5; k++) rd_chk(coef[p][39-8*k -: 8], "z readback");
         for (int ch = 0; ch < 4; ch++) chk_v(z_coeffs[ch], dec(coef[ch]), "z terms");
      end
      v = rnd8() & 8'hFD;
      wr(8'hC8, v);
      i_host.put(1'b1, 8'hC9);
      rd_chk(v, "dbc readback");
      for (int m = 0; m < 8; m++) begin
         pin_mode_selector = m[2];
         wr(8'hC8, {m[1], m[0], 6'h08});
         cyc(3);
         chk_v(mux_strobe_oe, m[1] & m[2], "strobe oe");
         for (n = 0; n < 1300 && z_filter_tick !== 1'b1; n++) @(negedge clk);
         n = 0;
         q = 0;
         do begin
            @(negedge clk);
            n++;
            if (mux_strobe_output === ~m[0]) q++;
         end while (z_filter_tick !== 1'b1 && n < 1300);
         chk_n(n, 1250, "tick period");
         if (m[1] & m[2]) chk_n(q, 1, "strobe pulses");
      end
      wr(8'hC8, 8'h09);
      for (n = 0; n < 200 && chopper_clock_out === 1'b0; n++) @(negedge clk);
      v[0] = chopper_clock_out;
      for (n = 0; n < 200 && chopper_clock_out === v[0]; n++) @(negedge clk);
      chk_n(n, 78, "chopper half period");
      wr(8'hC8, 8'h08);
      cyc(3);
      q = 0;
      repeat (200) begin
         @(negedge clk);
         if (chopper_clock_out !== 1'b0) q++;
      end
      chk_n(q, 0, "chopper off");
      hook_test(1, 2);
      chan_sel = 2'h1;
      wr(8'hE8, 8'h00);
      detect_input_one_b[1] = 1'b1;
      cyc(3);
      chk_v(rt_ground[1], 1'b1, "gk bypass");
      chan_sel = 2'h3;
      v = (rnd8() & 8'h0F) | 8'h02;
      wr(8'hE8, v);
      i_host.put(1'b1, 8'hE9);
      rd_chk(v, "gk readback");
      detect_input_one_b[3] = 1'b1;
      cyc(2);
      chk_v(rt_ground[3], 1'b0, "gk held");
      cyc((int'(v) + 1) * MS + 5);
      chk_v(rt_ground[3], 1'b1, "gk filtered");
      tx_interrupt_arm = 4'h5;
      for (int ch = 0; ch < 4; ch++) begin
         s = {rnd8(), rnd8()};
         linear_mode = ch[0];
         tx_in = '{valid: 1'b1, chan: ch[1:0], sample: s};
         @(negedge clk);
         tx_in = '{valid: 1'b0, chan: ~ch[1:0], sample: ~s};
         cyc(1);
         chk_v(tx_irq[ch], tx_interrupt_arm[ch], "irq set");
         chan_sel = ch[1:0];
         i_host.put(1'b1, 8'hCD);
         rd_chk(linear_mode ? s[15:8] : s[7:0], "tx byte");
         rd_chk(8'h00, "tx second byte");
         chk_v(tx_irq[ch], 1'b0, "irq clear");
      end
      rst = 1'b1;
      cyc(2);
      rst = 1'b0;
      i_host.put(1'b1, 8'hC9);
      rd_chk(8'h20, "dbc second reset");
      close_out();
   end
endmodule : line_codec_misc_command_regs_tb_top
